// >>> addr_guard.sv
// checks one rom address against the protection state
`include "rom_sec_cfg.svh"
module addr_guard
  import rom_sec_pkg::*;
(
  // protection
  input  prot_state_e      state,
  input  wire logic [5:0]  partition_value,
  // address
  input  wire logic [14:0] addr,
  output logic             denied
);
  logic [15:0] bound;
  // first unprotected address is (n+1)*512
  always_comb begin
    bound = 16'({10'h000, partition_value} + 16'h0001) << `BLOCK_SHIFT;
    case (state)
      PROT_GLOBAL: denied = 1'b1;
      PROT_BLOCK:  denied = ({1'b0, addr} < bound);
      default:     denied = 1'b0;
    endcase
  end
endmodule

// >>> prot_decode.sv
// decodes a protection word into a protection state
`include "rom_sec_cfg.svh"
module prot_decode
  import rom_sec_pkg::*;
(
  // raw word
  input  wire logic [16:0] word,
  // decoded
  output prot_fields_s     fields,
  output prot_state_e      state,
  output logic             parity_ok
);
  // field extraction and mode selection
  always_comb begin
    fields.partition_value   = word[`PW_PART_HI:`PW_PART_LO];
    fields.global_lock       = word[`PW_GLOBAL_BIT];
    fields.block_lock        = word[`PW_BLOCK_BIT];
    fields.complement_marker = word[`PW_COMP_HI:`PW_COMP_LO];
    parity_ok = (fields.complement_marker == ~fields.partition_value);
    if (!fields.global_lock) begin
      state = PROT_GLOBAL;
    end else if (!fields.block_lock) begin
      state = PROT_BLOCK;
    end else begin
      state = PROT_NONE;
    end
  end
endmodule

// >>> rom_model.sv
// far-side rom array model answering read pulses after one or four cycles
module rom_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // read port and the programmed protection word
  input  wire logic [14:0] rom_addr,
  input  wire logic        rom_rd,
  input  wire logic [16:0] pword,
  output logic      [16:0] rom_data,
  output logic             rom_data_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] at_reg;
  int          wait_cnt;
  bit          slow;
  initial rom_data = 17'h0_0000;
  // latch the address, answer with alternating latency, idle data keeps changing
  always @(posedge clk) begin
    rom_data_valid <= !rst && !rom_rd && wait_cnt == 1;
    if (rst) begin
      wait_cnt <= 0;
    end else if (rom_rd) begin
      at_reg <= rom_addr;
      wait_cnt <= slow ? 4 : 1;
      slow <= !slow;
    end else if (wait_cnt == 1) begin
      rom_data <= at_reg == 15'h7ffe ? pword : {2'b00, at_reg ^ 15'h2a5a};
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt > 0 ? wait_cnt - 1 : 0;
      rom_data <= ~rom_data;
    end
  end
endmodule

// >>> rom_sec_asserts.sv
// port-level checks for the rom vector map and code security block
module rom_sec_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // rom read port
  input wire logic [14:0] rom_addr,
  input wire logic        rom_rd,
  input wire logic [16:0] rom_data,
  input wire logic        rom_data_valid,
  // core side
  input wire logic        core_stall,
  input wire logic [15:0] core_pc_load,
  input wire logic        core_pc_load_valid,
  input wire logic [7:0]  irq_pending,
  input wire logic [7:0]  irq_enable,
  input wire logic        irq_ack,
  input wire logic [7:0]  short_vector_call_operand,
  input wire logic        short_vector_call_req,
  // scan check
  input wire logic        scan_req,
  input wire logic [14:0] scan_addr,
  input wire logic        scan_refuse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] last_reg;
  logic        busy_reg;
  logic [16:0] word_reg;
  logic        loaded_reg;
  logic [15:0] lim;
  logic [14:0] irq_vec;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // keep the last rom address asked and the protection word it returned
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_reg <= 1'b0;
    end else if (rom_data_valid && last_reg == 15'h7ffe) begin
      loaded_reg <= 1'b1;
      word_reg   <= rom_data;
    end
    if (rom_rd) begin
      last_reg <= rom_addr;
    end
    // a rom read is in flight from its request until its data returns
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (rom_rd) begin
      busy_reg <= 1'b1;
    end else if (rom_data_valid) begin
      busy_reg <= 1'b0;
    end
  end
  // first unprotected address and the vector of the winning irq level
  always_comb begin
    lim = ({10'd0, word_reg[14:9]} + 16'd1) << 9;
    irq_vec = 15'h7ff7;
    for (int i = 7; i >= 0; i--) begin
      if (irq_pending[i] && irq_enable[i]) begin
        irq_vec = 15'h7ff0 + 15'(i);
      end
    end
  end
  a_init_read: assert property ($fell(rst) |=> rom_rd && rom_addr == 15'h7ffe)
    else $error("protection word not fetched after reset release");
  a_stall_hold: assert property (core_stall && !rom_data_valid |=> core_stall)
    else $error("stall dropped without rom data");
  a_vector_pc: assert property (rom_data_valid && last_reg != 15'h7ffe &&
    last_reg[14:4] == 11'h7ff |=> core_pc_load_valid && {1'b0, core_pc_load} == $past(rom_data))
    else $error("vector word not loaded into pc");
  a_irq_vector: assert property (irq_ack && !core_stall && !busy_reg && !rom_rd &&
    (irq_pending & irq_enable) != 8'h00 |=> rom_rd && rom_addr == $past(irq_vec))
    else $error("wrong irq vector fetched");
  a_short_vector_call_target: assert property (short_vector_call_req && !core_stall && !irq_ack &&
    !busy_reg && !rom_rd |=> core_pc_load_valid && core_pc_load == {8'h7f, $past(short_vector_call_operand)})
    else $error("short vector call target wrong");
  a_global_deny: assert property (scan_req && !core_stall && loaded_reg && !word_reg[8]
    |=> scan_refuse)
    else $error("global lock let a scan through");
  a_block_split: assert property (scan_req && !core_stall && loaded_reg && word_reg[8] &&
    !word_reg[7] |=> scan_refuse == ({1'b0, $past(scan_addr)} < lim))
    else $error("block boundary misjudged");
  a_no_prot: assert property (scan_req && !core_stall && loaded_reg && word_reg[8] &&
    word_reg[7] |=> !scan_refuse)
    else $error("scan refused with no protection");
  c_irq: cover property (irq_ack && (irq_pending & irq_enable) != 8'h00);
  c_refuse: cover property (scan_refuse);
  c_short_vector_call: cover property (short_vector_call_req && !core_stall);
endmodule

// >>> rom_sec_cfg.svh
// constants for the rom vector map and code security logic
`ifndef ROM_SEC_CFG_SVH
`define ROM_SEC_CFG_SVH
`define ROM_VEC_BASE        15'h7ff0
`define ROM_RSV_FIRST       15'h7ff8
`define ROM_RSV_LAST        15'h7ffd
`define ROM_PROT_ADDR       15'h7ffe
`define ROM_RESET_VEC       15'h7fff
`define ROM_LAST_ADDR       15'h7fff
`define PW_PART_HI          14
`define PW_PART_LO          9
`define PW_GLOBAL_BIT       8
`define PW_BLOCK_BIT        7
`define PW_COMP_HI          5
`define PW_COMP_LO          0
`define PW_ERASED           17'h1_ffff
`define BLOCK_SHIFT         9
`define SHORT_VECTOR_CALL_HIGH_BYTE     8'h7f
`define REG_CTRL            12'h000
`define REG_STATUS          12'h004
`define REG_PWORD           12'h008
`define REG_IRQ             12'h00c
`define CTRL_INIT_BIT       0
`define CTRL_MODE_LO        1
`define CTRL_MODE_HI        2
`endif

// >>> rom_sec_pkg.sv
// types shared by the rom security block
package rom_sec_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_PROGRAM, MODE_EMULATE, MODE_TRACE} test_mode_e;
  typedef enum logic [1:0] {PROT_NONE, PROT_BLOCK, PROT_GLOBAL} prot_state_e;
  typedef struct packed {
    logic [5:0]  partition_value;
    logic        global_lock;
    logic        block_lock;
    logic [5:0]  complement_marker;
  } prot_fields_s;
  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
    logic        is_write;
  } rom_req_s;
endpackage

// >>> rom_vector_and_code_security.sv
// rom vector map and rom code security controller with apb registers
`include "rom_sec_cfg.svh"
module rom_vector_and_code_security
  import rom_sec_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // rom array read port, protection word and vectors
  output logic [14:0]      rom_addr,
  output logic             rom_rd,
  input  wire logic [16:0] rom_data,
  input  wire logic        rom_data_valid,
  // core side
  output logic             core_stall,
  output logic [15:0]      core_pc_load,
  output logic             core_pc_load_valid,
  input  wire logic [7:0]  irq_pending,
  input  wire logic [7:0]  irq_enable,
  input  wire logic        irq_ack,
  input  wire logic [7:0]  short_vector_call_operand,
  input  wire logic        short_vector_call_req,
  // lookup instruction check
  input  wire logic        lookup_req,
  input  wire logic [14:0] lookup_addr,
  input  wire logic [14:0] lookup_pc,
  output logic             lookup_refuse,
  output logic             lookup_external,
  // scan circuit check
  input  wire logic        scan_req,
  input  wire logic [14:0] scan_addr,
  output logic             scan_refuse
);
  typedef enum logic [2:0] {ST_LOAD_REQ, ST_LOAD_WAIT, ST_VEC_REQ, ST_VEC_WAIT,
                            ST_RUN, ST_IRQ_WAIT} seq_e;
  typedef struct packed {
    seq_e        seq;
    logic [16:0] sec_word;
    test_mode_e  mode;
    test_mode_e  pending_mode;
    logic        load_done;
    logic [14:0] rom_addr;
    logic        rom_rd;
    logic        stall;
    logic [15:0] pc_load;
    logic        pc_valid;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        lk_refuse;
    logic        lk_ext;
    logic        sc_refuse;
  } state_s;

  // whole state of the block and its next value
  state_s      cur_reg;
  state_s      cur_next;
  prot_fields_s fields;
  prot_state_e pstate;
  logic        parity_ok;
  // guard results and the interrupt choice
  logic        scan_deny;
  logic        lk_deny;
  logic        lk_pc_deny;
  logic [2:0]  irq_sel;
  logic        irq_any;

  // decode of the held security word
  prot_decode u_decode (
    .word      (cur_reg.sec_word),
    .fields    (fields),
    .state     (pstate),
    .parity_ok (parity_ok)
  );

  // scan access check
  addr_guard u_scan_guard (
    .state           (pstate),
    .partition_value (fields.partition_value),
    .addr            (scan_addr),
    .denied          (scan_deny)
  );

  // lookup checks: data and instruction side
  addr_guard u_lk_guard (
    .state           (pstate),
    .partition_value (fields.partition_value),
    .addr            (lookup_addr),
    .denied          (lk_deny)
  );
  addr_guard u_pc_guard (
    .state           (pstate),
    .partition_value (fields.partition_value),
    .addr            (lookup_pc),
    .denied          (lk_pc_deny)
  );

  // priority select, lowest index wins
  always_comb begin
    irq_sel = 3'd0;
    irq_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (irq_pending[i] && irq_enable[i]) begin
        irq_sel = 3'(i);
        irq_any = 1'b1;
      end
    end
  end

  // next state
  always_comb begin
    cur_next          = cur_reg;
    cur_next.rom_rd   = 1'b0;
    cur_next.pc_valid = 1'b0;
    cur_next.pready   = 1'b0;
    cur_next.pslverr  = 1'b0;
    // security checks, refused outside the unlocked block, scans also before the first load; lookups in emulation are never refused
    cur_next.sc_refuse = scan_req && (scan_deny || !cur_reg.load_done);
    cur_next.lk_ext    = lookup_req && (cur_reg.mode == MODE_EMULATE);
    cur_next.lk_refuse = lookup_req && (cur_reg.mode != MODE_EMULATE) &&
                         (lk_deny || (lk_pc_deny != lk_deny));
    case (cur_reg.seq)
      // ask for the protection word; power-up and test-mode entry both start here
      ST_LOAD_REQ: begin
        cur_next.stall    = 1'b1;
        cur_next.rom_addr = `ROM_PROT_ADDR;
        cur_next.rom_rd   = 1'b1;
        cur_next.seq      = ST_LOAD_WAIT;
      end
      // take the word; only the power-up pass goes on to the reset vector
      ST_LOAD_WAIT: begin
        if (rom_data_valid) begin
          cur_next.sec_word  = rom_data;
          cur_next.load_done = 1'b1;
          cur_next.mode      = cur_reg.pending_mode;
          cur_next.seq       = cur_reg.load_done ? ST_RUN : ST_VEC_REQ;
          cur_next.stall     = cur_reg.load_done ? 1'b0 : 1'b1;
        end
      end
      // power-up only: fetch the reset vector
      ST_VEC_REQ: begin
        cur_next.rom_addr = `ROM_RESET_VEC;
        cur_next.rom_rd   = 1'b1;
        cur_next.seq      = ST_VEC_WAIT;
      end
      // reset vector arrives: load pc and let the core run
      ST_VEC_WAIT: begin
        if (rom_data_valid) begin
          cur_next.pc_load  = rom_data[15:0];
          cur_next.pc_valid = 1'b1;
          cur_next.stall    = 1'b0;
          cur_next.seq      = ST_RUN;
        end
      end
      // interrupt vector arrives
      ST_IRQ_WAIT: begin
        if (rom_data_valid) begin
          cur_next.pc_load  = rom_data[15:0];
          cur_next.pc_valid = 1'b1;
          cur_next.seq      = ST_RUN;
        end
      end
      // an interrupt wins over a short vector call in the same cycle
      ST_RUN: begin
        if (irq_ack && irq_any) begin
          cur_next.rom_addr = `ROM_VEC_BASE + {12'h000, irq_sel};
          cur_next.rom_rd   = 1'b1;
          cur_next.seq      = ST_IRQ_WAIT;
        end else if (short_vector_call_req) begin
          cur_next.pc_load  = {`SHORT_VECTOR_CALL_HIGH_BYTE, short_vector_call_operand};
          cur_next.pc_valid = 1'b1;
        end
      end
      // unused codes fall back to a fresh load
      default: cur_next.seq = ST_LOAD_REQ;
    endcase
    // apb access phase, answered with one wait state
    if (psel && penable && !cur_reg.pready) begin
      cur_next.pready = 1'b1;
      cur_next.prdata = 32'h0000_0000;
      case (paddr)
        `REG_CTRL: begin
          if (pwrite) begin
            if (pwdata[`CTRL_INIT_BIT] && cur_reg.seq == ST_RUN) begin
              // mode entry always reruns the security load; a direct trace and
              // emulation swap runs in normal mode until that load completes
              if ((cur_reg.mode == MODE_TRACE &&
                   test_mode_e'(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]) == MODE_EMULATE) ||
                  (cur_reg.mode == MODE_EMULATE &&
                   test_mode_e'(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]) == MODE_TRACE)) begin
                cur_next.pending_mode = test_mode_e'(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
                cur_next.mode         = MODE_NORMAL;
              end else begin
                cur_next.pending_mode = test_mode_e'(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
              end
              cur_next.seq   = ST_LOAD_REQ;
              cur_next.stall = 1'b1;
              // drop a vector read started this cycle so that its data is
              // never mistaken for the protection word
              cur_next.rom_rd = 1'b0;
            end else begin
              cur_next.pslverr = 1'b1;
            end
          end else begin
            cur_next.prdata = {29'h0, cur_reg.mode, 1'b0};
          end
        end
        // status: parity, stall, protection state, load done
        `REG_STATUS: begin
          if (pwrite) begin
            cur_next.pslverr = 1'b1;
          end else begin
            cur_next.prdata = {26'h0, parity_ok, cur_reg.stall, pstate,
                               cur_reg.load_done, 1'b0};
          end
        end
        // held protection word, read only until the next load
        `REG_PWORD: begin
          if (pwrite) begin
            cur_next.pslverr = 1'b1;
          end else begin
            cur_next.prdata = {15'h0, cur_reg.sec_word};
          end
        end
        // levels that are both pending and enabled
        `REG_IRQ: begin
          if (pwrite) begin
            cur_next.pslverr = 1'b1;
          end else begin
            cur_next.prdata = {24'h0, irq_pending & irq_enable};
          end
        end
        default: cur_next.pslverr = 1'b1;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg.seq          <= ST_LOAD_REQ;
      cur_reg.sec_word     <= `PW_ERASED;
      cur_reg.mode         <= MODE_NORMAL;
      cur_reg.pending_mode <= MODE_NORMAL;
      cur_reg.load_done    <= 1'b0;
      cur_reg.rom_addr     <= 15'h0000;
      cur_reg.rom_rd       <= 1'b0;
      cur_reg.stall        <= 1'b1;
      cur_reg.pc_load      <= 16'h0000;
      cur_reg.pc_valid     <= 1'b0;
      cur_reg.prdata       <= 32'h0000_0000;
      cur_reg.pready       <= 1'b0;
      cur_reg.pslverr      <= 1'b0;
      cur_reg.lk_refuse    <= 1'b0;
      cur_reg.lk_ext       <= 1'b0;
      cur_reg.sc_refuse    <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // outputs straight from the state register
  assign prdata             = cur_reg.prdata;
  assign pready             = cur_reg.pready;
  assign pslverr            = cur_reg.pslverr;
  assign rom_addr           = cur_reg.rom_addr;
  assign rom_rd             = cur_reg.rom_rd;
  assign core_stall         = cur_reg.stall;
  assign core_pc_load       = cur_reg.pc_load;
  assign core_pc_load_valid = cur_reg.pc_valid;
  assign lookup_refuse      = cur_reg.lk_refuse;
  assign lookup_external    = cur_reg.lk_ext;
  assign scan_refuse        = cur_reg.sc_refuse;
endmodule

// >>> tb_top.sv
// self-checking bench for the rom vector map and code security block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, irq_ack = 0;
  logic        short_vector_call_req = 0, lookup_req = 0, scan_req = 0, emu = 0, er;
  logic        pready, pslverr, rom_rd, rom_data_valid, core_stall, core_pc_load_valid;
  logic        lookup_refuse, lookup_external, scan_refuse;
  logic [7:0]  irq_pending = 0, irq_enable = 0, short_vector_call_operand = 0;
  logic [11:0] paddr = 0;
  logic [14:0] rom_addr, lookup_addr = 0, lookup_pc = 0, scan_addr = 0, a;
  logic [15:0] core_pc_load, pcq[$];
  logic [16:0] rom_data, pword = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int          fails = 0, n_tests = 0, loads = 0, cnt, lim;
  rom_vector_and_code_security uut (.*);
  rom_model far_rom (.*);
  initial forever #10 clk = ~clk;
  // collect pc loads and protection word fetches where outputs are settled
  always @(negedge clk) begin
    if (core_pc_load_valid) pcq.push_back(core_pc_load);
    if (rom_rd && rom_addr == 15'h7ffe) loads++;
  end
  function automatic int deny(logic [16:0] w, logic [14:0] x);
    if (!w[8]) return 1;
    if (!w[7]) return int'(x) < (int'(w[14:9]) + 1) * 512;
    return 0;
  endfunction
  function automatic logic [31:0] take();
    if (pcq.size() == 0) return 'x;
    return pcq.pop_front();
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready) begin
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        return;
      end
    end
    fails++;
    close_out();
  endtask
  // bounded waits for the end of a stall or for a pc load
  task automatic wait_run();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (!core_stall) return;
    end
    fails++;
    close_out();
  endtask
  task automatic wait_pc();
    for (int i = 0; i < 12 && pcq.size() == 0; i++) @(posedge clk);
    @(negedge clk);
  endtask
  // one scan and one lookup request against the model's expectation
  task automatic probe(input logic [14:0] x, input logic [14:0] pc);
    @(posedge clk);
    scan_req <= 1;
    scan_addr <= x;
    lookup_req <= 1;
    lookup_addr <= x;
    lookup_pc <= pc;
    @(posedge clk);
    scan_req <= 0;
    lookup_req <= 0;
    @(negedge clk);
    chk(scan_refuse, deny(pword, x));
    chk(lookup_refuse, !emu && (deny(pword, x) || deny(pword, pc)));
    chk(lookup_external, emu);
  endtask
  initial begin
    void'($urandom(86543));
    cnt = $urandom % 64;
    pword = {2'b11, cnt[5:0], 3'b101, ~cnt[5:0]};
    repeat (5) @(posedge clk);
    rst <= 0;
    wait_run();
    chk(loads, 1);
    chk(take(), {16'h0000, 1'b0, 15'h7fff ^ 15'h2a5a});
    // irq levels and short vector calls in normal run
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      irq_pending <= i == 0 ? 8'h00 : 8'($urandom);
      irq_enable <= i == 1 ? 8'h00 : 8'($urandom) | 8'h80;
      short_vector_call_operand <= 8'($urandom);
      @(posedge clk);
      irq_ack <= 1;
      @(posedge clk);
      irq_ack <= 0;
      wait_pc();
      cnt = -1;
      for (int j = 7; j >= 0; j--) if (irq_pending[j] && irq_enable[j]) cnt = j;
      chk(take(), cnt < 0 ? 32'hxxxx_xxxx : {17'h0_0000, 15'h7ff0 + 15'(cnt) ^ 15'h2a5a});
      apb(0, 12'h00c, 0);
      chk(rd & 32'h0000_00ff, irq_pending & irq_enable);
      @(posedge clk);
      short_vector_call_req <= 1;
      @(posedge clk);
      short_vector_call_req <= 0;
      wait_pc();
      chk(take(), {16'h7f00 | short_vector_call_operand});
    end
    // block word, then global lock in trace mode, then erased word in emulation
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        pword <= k == 1 ? pword & 17'h1_feff : 17'h1_ffff;
        cnt = loads;
        apb(1, 12'h000, k == 1 ? 32'h0000_0007 : 32'h0000_0005);
        chk(er, 0);
        wait_run();
        chk(loads > cnt, 1);
        apb(0, 12'h000, 0);
        chk(rd & 32'h0000_0006, k == 1 ? 32'h0000_0006 : 32'h0000_0004);
      end
      emu = k == 2;
      apb(0, 12'h004, 0);
      chk(rd & 32'h0000_003e, {pword[14:9] == ~pword[5:0], 1'b0,
        !pword[8] ? 2'd2 : !pword[7] ? 2'd1 : 2'd0, 2'b10});
      apb(0, 12'h008, 0);
      chk(rd, {15'h0000, pword});
      lim = (int'(pword[14:9]) + 1) * 512;
      for (int i = 0; i < 6; i++) begin
        a = i == 0 ? 15'(lim - 1) : i == 1 ? 15'(lim) : 15'($urandom);
        probe(a, i < 2 ? a : 15'($urandom));
      end
    end
    // mid-run reset: full reload and reset vector again, scans refused until loaded
    cnt = loads;
    @(posedge clk);
    rst <= 1;
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    scan_req <= 1;
    scan_addr <= 15'h7fff;
    @(posedge clk);
    scan_req <= 0;
    @(negedge clk);
    chk(scan_refuse, 1);
    chk(core_stall, 1);
    wait_run();
    chk(loads, cnt + 1);
    chk(take(), {16'h0000, 1'b0, 15'h7fff ^ 15'h2a5a});
    // reset leaves emulation: lookups are served internally again
    emu = 0;
    probe(15'h0000, 15'h7fff);
    // refused register accesses
    apb(1, 12'h004, 32'h0000_0001);
    chk(er, 1);
    apb(0, 12'h010, 0);
    chk(er, 1);
    apb(1, 12'h000, 32'h0000_0000);
    chk(er, 1);
    close_out();
  end
endmodule
bind rom_vector_and_code_security rom_sec_asserts chk_i (.*);
